// file: hw/flash_cmd_dev.sv
// device end: decodes page buffer operations and streams status
// assumes host drives the link in spi mode 0 at most ref_clk/8
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

module flash_cmd_dev
	import flash_seq_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	// link
	spi_link_if.dev                   link,
	// configuration from the array side
	input  wire logic                 page_size_512,
	input  wire logic                 protect_en,
	input  wire logic                 compare_differs,
	// operation requests to the array side
	output logic                      op_start,
	output op_kind_t                  op_kind,
	output logic                      op_buf2,
	output logic [PAGE_BITS-1:0]      page_number_bits,
	output logic                      busy
);

	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_LOAD = 2'b01,
		D_COMP = 2'b10,
		D_BACK = 2'b11
	} dev_state_t;

	// =========================================================
	// input synchronisers
	logic [2:0]            cs_sq;
	logic [2:0]            sck_sq;
	logic [1:0]            si_sq;
	logic                  sck_rise;
	logic                  sck_fall;
	logic                  cs_rise;
	logic                  cs_low;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_sq  <= 3'h7;
			sck_sq <= 3'h0;
			si_sq  <= 2'h0;
		end else begin
			cs_sq  <= {cs_sq[1:0], link.cs_n};
			sck_sq <= {sck_sq[1:0], link.sck};
			si_sq  <= {si_sq[0], link.si};
		end
	end

	assign cs_low   = ~cs_sq[1];
	assign cs_rise  = cs_sq[1] & ~cs_sq[2];
	assign sck_rise = cs_low & sck_sq[1] & ~sck_sq[2];
	assign sck_fall = cs_low & ~sck_sq[1] & sck_sq[2];

	// =========================================================
	// command shifter
	logic [FRAME_BITS-1:0] sh_q;
	logic [5:0]            cnt_q;
	logic                  stat_mode_q;
	logic [FRAME_BITS-1:0] sh_d;

	assign sh_d = {sh_q[FRAME_BITS-2:0], si_sq[1]};

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_q  <= '0;
			cnt_q <= 6'h0;
		end else if (!cs_low) begin
			cnt_q <= 6'h0;
		end else if (sck_rise) begin
			sh_q <= sh_d;
			// stop one past a full frame so longer frames never launch
			if (cnt_q != 6'(FRAME_BITS + 1))
				cnt_q <= cnt_q + 6'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_mode_q <= 1'b0;
		end else if (!cs_low) begin
			stat_mode_q <= 1'b0;
		end else if (sck_rise && cnt_q == 6'(OPC_BITS - 1)
				&& sh_d[OPC_BITS-1:0] == OP_STATUS) begin
			stat_mode_q <= 1'b1;
		end
	end

	// =========================================================
	// opcode and address decode at select release
	logic                  valid_op;
	logic                  buf2_d;
	op_kind_t              kind_d;
	logic [PAGE_BITS-1:0]  page_d;
	logic [23:0]           addr;

	assign addr = sh_q[23:0];

	always_comb begin
		valid_op = 1'b1;
		kind_d   = KIND_LOAD;
		unique case (sh_q[31:24])
			OP_LOAD_B1, OP_LOAD_B2:       kind_d = KIND_LOAD;
			OP_COMP_B1, OP_COMP_B2:       kind_d = KIND_COMPARE;
			OP_REFRESH_B1, OP_REFRESH_B2: kind_d = KIND_REFRESH;
			default:                      valid_op = 1'b0;
		endcase
		// buffer choice is not one opcode bit for every kind
		buf2_d = sh_q[31:24] == OP_LOAD_B2
			|| sh_q[31:24] == OP_COMP_B2
			|| sh_q[31:24] == OP_REFRESH_B2;
		if (page_size_512)
			page_d = addr[LSB_512 +: PAGE_BITS];
		else
			page_d = addr[LSB_528 +: PAGE_BITS];
	end

	// =========================================================
	// self-timed operation sequencer
	dev_state_t            st_q;
	logic [11:0]           tmr_q;
	logic                  comp_q;
	logic                  launch;
	logic                  tmr_done;

	assign launch   = cs_rise && cnt_q == 6'(FRAME_BITS) && valid_op
		&& st_q == D_IDLE;
	assign tmr_done = tmr_q == 12'h0;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q  <= D_IDLE;
			tmr_q <= 12'h0;
		end else begin
			if (!tmr_done)
				tmr_q <= tmr_q - 12'h1;
			unique case (st_q)
				D_IDLE: if (launch) begin
					st_q  <= kind_d == KIND_COMPARE ? D_COMP : D_LOAD;
					tmr_q <= kind_d == KIND_COMPARE ? COMPARE_CYC - 12'h1
						: PAGE_LOAD_CYC - 12'h1;
				end
				D_LOAD: if (tmr_done) begin
					st_q  <= op_kind == KIND_REFRESH ? D_BACK : D_IDLE;
					tmr_q <= WRITEBACK_CYC - 12'h1;
				end
				D_COMP: if (tmr_done)
					st_q <= D_IDLE;
				D_BACK: if (tmr_done)
					st_q <= D_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			op_start         <= 1'b0;
			op_kind          <= KIND_LOAD;
			op_buf2          <= 1'b0;
			page_number_bits <= '0;
		end else begin
			op_start <= launch;
			if (launch) begin
				op_kind          <= kind_d;
				op_buf2          <= buf2_d;
				page_number_bits <= page_d;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			comp_q <= 1'b0;
		else if (st_q == D_COMP && tmr_done)
			comp_q <= compare_differs;
	end

	assign busy = st_q != D_IDLE;

	// =========================================================
	// status streaming
	logic [7:0]            byte_one;
	logic [7:0]            byte_two;
	logic [7:0]            out_sh_q;
	logic [2:0]            out_bit_q;
	logic                  sel_two_q;
	logic                  so_q;
	logic                  oe_q;
	logic [7:0]            word;

	always_comb begin
		byte_one                          = 8'h00;
		byte_one[ST_READY]                = ~busy;
		byte_one[ST_COMP]                 = comp_q;
		byte_one[ST_DENS_LO +: 4]         = DENSITY_CODE;
		byte_one[ST_PROTECT]              = protect_en;
		byte_one[ST_PSIZE]                = page_size_512;
		byte_two                          = 8'h00;
		byte_two[ST_READY]                = ~busy;
		word = sel_two_q ? byte_two : byte_one;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_sh_q  <= 8'h00;
			out_bit_q <= 3'h0;
			sel_two_q <= 1'b0;
			so_q      <= 1'b0;
			oe_q      <= 1'b0;
		end else if (!stat_mode_q) begin
			out_bit_q <= 3'h0;
			sel_two_q <= 1'b0;
			oe_q      <= 1'b0;
		end else if (sck_fall) begin
			out_bit_q <= out_bit_q + 3'h1;
			oe_q      <= 1'b1;
			if (out_bit_q == 3'h0) begin
				so_q      <= word[7];
				out_sh_q  <= {word[6:0], 1'b0};
				sel_two_q <= ~sel_two_q;
			end else begin
				so_q     <= out_sh_q[7];
				out_sh_q <= {out_sh_q[6:0], 1'b0};
			end
		end
	end

	assign link.so    = so_q;
	assign link.so_oe = oe_q & cs_low;

endmodule

// file: hw/flash_cmd_host.sv
// host end: issues one flash command per register order
// assumes avalon-mm master on ref_clk; makes sck as ref_clk/16
`timescale 1ns/100ps
module flash_cmd_host
	import flash_seq_pkg::*;
(
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// avalon-mm slave
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	// link
	spi_link_if.host          link
);

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_SHIFT = 2'b01,
		H_GAP   = 2'b10
	} host_state_t;

	// =========================================================
	// register bus
	host_state_t      st_q;
	logic             ack_q;
	logic             wr_cmd;
	logic [7:0]       stat_q;

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_cmd = avs_write & ack_q & avs_address == REG_CMD
		& st_q == H_IDLE;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
			if (avs_address == REG_STAT)
				avs_readdata <= {16'h0, stat_q, 7'h0, st_q != H_IDLE};
			else
				avs_readdata <= 32'h0;
		end
	end

	// =========================================================
	// so synchroniser and clock divider
	logic [1:0]       so_sq;
	logic [3:0]       div_q;
	logic             tick;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			so_sq <= 2'h0;
		else
			so_sq <= {so_sq[0], link.so};
	end

	assign tick = div_q == SCK_HALF - 4'h1;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			div_q <= 4'h0;
		else if (st_q == H_IDLE || tick)
			div_q <= 4'h0;
		else
			div_q <= div_q + 4'h1;
	end

	// =========================================================
	// frame sequencer
	logic [31:0]      tx_q;
	logic [7:0]       rx_q;
	logic [5:0]       bits_q;
	logic             poll_q;
	logic             sck_q;
	logic             cs_n_q;
	logic [23:0]      addr_d;
	logic [PAGE_BITS-1:0] pg;
	logic             byte_done;

	assign pg = avs_writedata[CMD_PAGE_LO +: PAGE_BITS];
	assign addr_d = avs_writedata[CMD_PSIZE]
		? 24'({pg, 9'h0})
		: 24'({pg, 10'h0});
	assign byte_done = bits_q[2:0] == 3'h0;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q   <= H_IDLE;
			tx_q   <= 32'h0;
			rx_q   <= 8'h00;
			bits_q <= 6'h0;
			poll_q <= 1'b0;
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
			stat_q <= 8'h00;
		end else begin
			unique case (st_q)
				H_IDLE: if (wr_cmd) begin
					tx_q   <= {avs_writedata[7:0], addr_d};
					poll_q <= avs_writedata[7:0] == OP_STATUS;
					bits_q <= 6'h0;
					cs_n_q <= 1'b0;
					st_q   <= H_SHIFT;
				end
				H_SHIFT: if (tick) begin
					sck_q <= ~sck_q;
					if (!sck_q) begin
						rx_q   <= {rx_q[6:0], so_sq[1]};
						bits_q <= bits_q == BITS_WRAP ? BITS_REWIND
							: bits_q + 6'h1;
					end else if (!poll_q
							&& bits_q == 6'(FRAME_BITS)) begin
						cs_n_q <= 1'b1;
						st_q   <= H_GAP;
					end else if (poll_q && byte_done
							&& bits_q != 6'(OPC_BITS)) begin
						stat_q <= rx_q;
						if (rx_q[ST_READY]) begin
							cs_n_q <= 1'b1;
							st_q   <= H_GAP;
						end
					end else begin
						tx_q <= {tx_q[30:0], 1'b0};
					end
				end
				H_GAP: if (tick)
					st_q <= H_IDLE;
				default: st_q <= H_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sck  = sck_q;
	assign link.si   = tx_q[31];

endmodule

// file: hw/flash_seq_pkg.sv
// constants shared by both ends of the serial flash command link
// assumes a 40 MHz ref_clk on both ends
package flash_seq_pkg;

	// =========================================================
	// opcodes
	localparam logic [7:0] OP_LOAD_B1    = 8'h53;
	localparam logic [7:0] OP_LOAD_B2    = 8'h55;
	localparam logic [7:0] OP_COMP_B1    = 8'h60;
	localparam logic [7:0] OP_COMP_B2    = 8'h61;
	localparam logic [7:0] OP_REFRESH_B1 = 8'h58;
	localparam logic [7:0] OP_REFRESH_B2 = 8'h59;
	localparam logic [7:0] OP_STATUS     = 8'hd7;

	// =========================================================
	// frame and address layout
	localparam int OPC_BITS    = 8;
	localparam int FRAME_BITS  = 32;
	localparam int PAGE_BITS   = 13;
	localparam int LSB_528     = 10;
	localparam int LSB_512     = 9;

	// =========================================================
	// status byte one fields
	localparam int ST_READY    = 7;
	localparam int ST_COMP     = 6;
	localparam int ST_DENS_LO  = 2;
	localparam int ST_PROTECT  = 1;
	localparam int ST_PSIZE    = 0;
	// density code: value is arbitrary
	localparam logic [3:0] DENSITY_CODE = 4'h0;

	// =========================================================
	// self-timed operation durations
	localparam int CLK_NS              = 25;
	localparam int PAGE_LOAD_TIME_NS   = 20000;
	localparam int COMPARE_TIME_NS     = 20000;
	localparam int REFRESH_CYCLE_TIME_NS = 60000;
	localparam logic [11:0] PAGE_LOAD_CYC =
		12'(PAGE_LOAD_TIME_NS / CLK_NS);
	localparam logic [11:0] COMPARE_CYC =
		12'(COMPARE_TIME_NS / CLK_NS);
	localparam logic [11:0] WRITEBACK_CYC =
		12'((REFRESH_CYCLE_TIME_NS - PAGE_LOAD_TIME_NS) / CLK_NS);

	// =========================================================
	// host side link clock and register map
	localparam logic [3:0] SCK_HALF     = 4'h8;
	localparam logic [3:0] REG_CMD      = 4'h0;
	localparam logic [3:0] REG_STAT     = 4'h4;
	localparam int CMD_PAGE_LO          = 8;
	localparam int CMD_PSIZE            = 24;
	localparam int STAT_BYTE_LO         = 8;
	localparam logic [5:0] BITS_WRAP    = 6'h3f;
	localparam logic [5:0] BITS_REWIND  = 6'h20;

	typedef enum logic [1:0] {
		KIND_LOAD    = 2'b00,
		KIND_COMPARE = 2'b01,
		KIND_REFRESH = 2'b10
	} op_kind_t;

endpackage

// file: hw/spi_link_if.sv
// serial link between the host controller and the flash command block
// assumes both ends run on the same kind of ref_clk; sck is made by host
`timescale 1ns/100ps
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;

	modport dev  (input cs_n, sck, si, output so, so_oe);
	modport host (output cs_n, sck, si, input so, so_oe);
endinterface

// file: verification/flash_link_monitor.sv
// checker: timing relations on the flash command link
// assumes it sits beside the link interface in the bench
`timescale 1ns/100ps
module flash_link_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic so,
	input wire logic so_oe,
	// device operation outputs
	input wire logic op_start,
	input wire logic busy
);
	// ========
	// helper counters
	logic [11:0] busy_cnt_q;
	logic [5:0]  rise_cnt_q;
	logic        sck_q;
	logic        cs_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			busy_cnt_q <= 12'h000;
		else if (busy)
			busy_cnt_q <= busy_cnt_q + 12'h001;
		else
			busy_cnt_q <= 12'h000;
	end

	// sck rises per frame, held after the frame ends
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			rise_cnt_q <= 6'h00;
		end else begin
			sck_q <= sck;
			cs_q <= cs_n;
			if (cs_q && !cs_n)
				rise_cnt_q <= 6'h00;
			else if (!cs_n && sck && !sck_q && rise_cnt_q != 6'h3f)
				rise_cnt_q <= rise_cnt_q + 6'h01;
		end
	end

	// ========
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_start_frame;
		op_start |-> cs_n && rise_cnt_q == 6'h20;
	endproperty
	a_start_frame: assert property (p_start_frame)
		else $error("launch without a full frame");

	property p_start_busy;
		op_start |-> ##1 busy[*8];
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("busy missing after launch");

	property p_no_nest;
		busy && $past(busy) |-> !op_start;
	endproperty
	a_no_nest: assert property (p_no_nest)
		else $error("launch while busy");

	property p_busy_len;
		$fell(busy) |-> busy_cnt_q inside {[12'h31f:12'h321],
			[12'h95f:12'h961]};
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");

	property p_oe_gone;
		$rose(cs_n) |-> ##[1:4] !so_oe;
	endproperty
	a_oe_gone: assert property (p_oe_gone)
		else $error("so not released after deselect");

	property p_oe_quiet;
		cs_n[*5] |-> !so_oe;
	endproperty
	a_oe_quiet: assert property (p_oe_quiet)
		else $error("so driven while deselected");

	property p_oe_opcode;
		$rose(so_oe) |-> !cs_n && rise_cnt_q == 6'h08;
	endproperty
	a_oe_opcode: assert property (p_oe_opcode)
		else $error("status output not after opcode");

	property p_so_steady;
		so_oe && $rose(sck) |-> $stable(so);
	endproperty
	a_so_steady: assert property (p_so_steady)
		else $error("so moved at sampling edge");

	property p_cs_still;
		cs_n[*2] |-> !sck;
	endproperty
	a_cs_still: assert property (p_cs_still)
		else $error("sck toggles outside frame");

	c_op: cover property (op_start);
	c_long: cover property ($fell(busy) && busy_cnt_q > 12'h900);
	c_poll_busy: cover property ($rose(so_oe) && busy);
endmodule

// file: verification/testbench.sv
// testbench: host and device joined, host driven over avalon-mm
// assumes the hw/ files are compiled first
`timescale 1ns/100ps
module testbench;
	import flash_seq_pkg::*;
	typedef struct packed {
		logic [7:0]  op;
		logic [12:0] pg;
		logic        ps, pr, df;
		op_kind_t    kind;
		logic        b2;
	} row_t;
	logic                 ref_clk, arst_n, ps, pr, df, rd, wr, wt;
	logic                 start_o, buf2_o, busy_o, saw, comp;
	logic [3:0]           adr;
	logic [31:0]          wd, rdata, rv, sh;
	logic [PAGE_BITS-1:0] pg_o;
	op_kind_t             kind_o;
	int                   fail_count, tests_run, cyc, starts, n;
	row_t                 rows [6];
	spi_link_if link_w();
	flash_cmd_host i_flash_cmd_host (.ref_clk(ref_clk), .arst_n(arst_n),
		.avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdata),
		.avs_waitrequest(wt), .link(link_w));
	flash_cmd_dev i_flash_cmd_dev (.ref_clk(ref_clk), .arst_n(arst_n),
		.link(link_w), .page_size_512(ps), .protect_en(pr),
		.compare_differs(df), .op_start(start_o), .op_kind(kind_o),
		.op_buf2(buf2_o), .page_number_bits(pg_o), .busy(busy_o));
	flash_link_monitor i_flash_link_monitor (.ref_clk(ref_clk),
		.arst_n(arst_n), .cs_n(link_w.cs_n), .sck(link_w.sck),
		.so(link_w.so), .so_oe(link_w.so_oe), .op_start(start_o),
		.busy(busy_o));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ========
	// link capture and run limit
	always @(posedge link_w.sck) if (!link_w.cs_n) sh <= {sh[30:0], link_w.si};
	always @(posedge ref_clk) begin
		if (start_o === 1'b1)
			starts <= starts + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ========
	// tasks
	task check(input string what, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do @(posedge ref_clk); while (wt !== 1'b0);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task idle;
		do bus(1'b0, REG_STAT, 32'h0); while (rv[0] !== 1'b0);
	endtask
	// saw is set when any stored byte showed the device busy
	task poll(output logic s);
		s = 1'b0;
		idle();
		bus(1'b1, REG_CMD, {24'h0, OP_STATUS});
		do begin
			bus(1'b0, REG_STAT, 32'h0);
			if (rv[15] === 1'b0)
				s = 1'b1;
		end while (rv[0] !== 1'b0);
	endtask
	task launch(input logic [31:0] cmd);
		n = starts;
		bus(1'b1, REG_CMD, cmd);
		wait (starts != n);
		@(negedge ref_clk);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ========
	// main sequence
	initial begin
		{arst_n, rd, wr, ps, pr, df, comp} = 7'h00;
		{adr, wd, cyc, starts, fail_count, tests_run} = '0;
		rows = '{'{OP_LOAD_B1, 13'h1fff, 1'h0, 1'h0, 1'h0, KIND_LOAD, 1'h0},
			'{OP_LOAD_B2, 13'h0000, 1'h1, 1'h0, 1'h1, KIND_LOAD, 1'h1},
			'{OP_COMP_B1, 13'h0aaa, 1'h0, 1'h1, 1'h1, KIND_COMPARE, 1'h0},
			'{OP_COMP_B2, 13'h1555, 1'h1, 1'h0, 1'h0, KIND_COMPARE, 1'h1},
			'{OP_REFRESH_B1, 13'h0001, 1'h0, 1'h0, 1'h1, KIND_REFRESH,
				1'h0},
			'{OP_REFRESH_B2, 13'h1000, 1'h1, 1'h1, 1'h1, KIND_REFRESH,
				1'h1}};
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		bus(1'b0, 4'h8, 32'h1);
		check("unmapped read", 32'h0, rv);
		foreach (rows[i]) begin
			ps <= rows[i].ps;
			pr <= rows[i].pr;
			df <= rows[i].df;
			launch({7'h0, rows[i].ps, 3'h0, rows[i].pg, rows[i].op});
			check("frame", {rows[i].op, rows[i].ps ? {2'h0, rows[i].pg,
				9'h0} : {1'h0, rows[i].pg, 10'h0}}, sh);
			check("decode", {rows[i].kind, rows[i].b2, rows[i].pg},
				{kind_o, buf2_o, pg_o});
			if (rows[i].op[7:1] == 7'h30)
				comp = rows[i].df;
			poll(saw);
			check("busy byte seen", 1, saw);
			check("busy cleared", 0, busy_o);
			poll(saw);
			check("status", {1'b1, comp, DENSITY_CODE, rows[i].pr,
				rows[i].ps}, rv[15:8]);
		end
		// a load while a refresh runs is dropped, so is a bad opcode
		launch({24'h0, OP_REFRESH_B2});
		idle();
		bus(1'b1, REG_CMD, {24'h0, OP_LOAD_B1});
		idle();
		repeat (8) @(posedge ref_clk);
		check("launch count", n + 1, starts);
		check("refresh busy", 1, busy_o);
		poll(saw);
		bus(1'b1, REG_CMD, 32'h12);
		idle();
		repeat (8) @(posedge ref_clk);
		check("bad opcode", n + 1, starts);
		arst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("reset state", 4'h2, {busy_o, link_w.so_oe, link_w.cs_n,
			link_w.sck});
		arst_n <= 1'b1;
		poll(saw);
		check("ready after reset", 1, rv[15]);
		report_and_stop();
	end
endmodule
